//--- hw/octet_fifo.sv
module octet_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int LW    = $clog2(DEPTH + 2)
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data,
    output logic [LW-1:0]         level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [LW-1:0]    acnt;
    logic             out_full;
    logic             push;
    logic             pop;
    logic             load;

    assign wr_ready = (acnt != LW'(DEPTH));
    assign push     = wr_valid && wr_ready;
    assign pop      = rd_valid && rd_ready;
    assign load     = (acnt != '0) && (!out_full || pop);
    assign rd_valid = out_full;
    assign level    = acnt + LW'(out_full);

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem[wptr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wptr <= '0;
            rptr <= '0;
            acnt <= '0;
        end else if (ce) begin
            if (push) begin
                wptr <= bump(wptr);
            end
            if (load) begin
                rptr <= bump(rptr);
            end
            acnt <= acnt + LW'(push) - LW'(load);
        end
    end

    // Read data always come out of this register
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_full <= 1'b0;
            rd_data  <= '0;
        end else if (ce) begin
            if (load) begin
                rd_data  <= mem[rptr];
                out_full <= 1'b1;
            end else if (pop) begin
                out_full <= 1'b0;
            end
        end
    end

endmodule : octet_fifo

//--- hw/octet_serializer.sv
`include "ovh_defs.svh"

module octet_serializer #(
    parameter int BIT_CYCLES = `OVH_BIT_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic [7:0] hold_data,
    input  wire logic       force_ones,
    output ovh_pkg::serial_t ch,
    output logic            bit_end,
    output logic            octet_end
);
    localparam int CW = $clog2(BIT_CYCLES);

    logic [CW-1:0] div;
    logic [2:0]    bitn;
    logic [7:0]    shreg;
    logic          clk_r;
    logic          frame_r;

    assign bit_end   = ce && (div == CW'(BIT_CYCLES - 1));
    assign octet_end = bit_end && (bitn == 3'h7);
    assign ch        = '{clk: clk_r, data: shreg[7], frame: frame_r};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            div   <= '0;
            clk_r <= 1'b0;
        end else if (ce) begin
            div <= bit_end ? '0 : div + 1'b1;
            // Low for the first half of a bit, rising at mid-bit
            if (div == CW'(BIT_CYCLES / 2 - 1)) begin
                clk_r <= 1'b1;
            end else if (bit_end) begin
                clk_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bitn    <= 3'h0;
            shreg   <= `OVH_ALL_ONES;
            frame_r <= 1'b0;
        end else if (ce && bit_end) begin
            bitn <= bitn + 3'h1;
            if (octet_end) begin
                // Fill decided per octet: at most one octet late
                shreg   <= force_ones ? `OVH_ALL_ONES : hold_data;
                frame_r <= 1'b1;
            end else begin
                shreg   <= {shreg[6:0], 1'b1};
                frame_r <= 1'b0;
            end
        end
    end

    chk_octet_frame : assert property (@(posedge sys_clk) disable iff (reset)
        octet_end |=> ch.frame && !ch.clk)
        else $error("serial octet did not start with frame mark");

endmodule : octet_serializer

//--- hw/ovh_defs.svh
`ifndef OVH_DEFS_SVH
`define OVH_DEFS_SVH

// Clock period and serial bit time, in ns
`define OVH_CLK_NS        25
`define OVH_BIT_NS        15625
`define OVH_BIT_CYCLES    (`OVH_BIT_NS / `OVH_CLK_NS)

// Frame period and wander the elastic store must ride out, in ns
`define OVH_FRAME_NS      125000
`define OVH_WANDER_NS     18000

// Elastic store
`define OVH_STORE_DEPTH   8
`define OVH_LOW_MARK      4'h1
`define OVH_MID_MARK      4'h4
`define OVH_HIGH_MARK     4'h7

// Values
`define OVH_ALL_ONES      8'hFF
`define OVH_SEL_E1        1'b0
`define OVH_SEL_F1        1'b1

`endif

//--- hw/ovh_pkg.sv
package ovh_pkg;

    typedef enum logic [1:0] {
        SRC_PRIME = 2'b00,
        SRC_RUN   = 2'b01
    } src_state_t;

    // Overhead slot strobes on the line clock
    typedef struct packed {
        logic e1;
        logic f1;
    } ovh_slot_t;

    // Received overhead byte with its position strobes
    typedef struct packed {
        logic       e1;
        logic       f1;
        logic [7:0] data;
    } ovh_rx_t;

    // Byte offered to the section termination
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ovh_tx_t;

    // 64 kbit/s serial channel: clock, data, octet start
    typedef struct packed {
        logic clk;
        logic data;
        logic frame;
    } serial_t;

endpackage : ovh_pkg

//--- hw/sdh_64k_overhead_channel_adapt.sv
// Behaviour
// - Octet source inserts each channel octet into E1 or F1, as provisioned.
// - Elastic store written from channel clock, read at the selected slot.
// - Positive slip discards one whole stored octet, once.
// - Negative slip sends the same stored octet again in next slot.
// - Store depth absorbs at least 18 us wander without bit errors.
// - Octet sink extracts the provisioned E1 or F1 byte once per frame.
// - Octet sink latches each received octet in a store on line clock.
// - Stored octet shifts out serially on a nominal 64 kHz clock.
// - Trail fail sets server fail and all-ones within 1 ms; resumes likewise.
// - User source fills F1 only and supplies line-derived channel clock.
// - User sink extracts F1, delivers it with clock and fail indication.
// - Trail fail gives user server fail and all-ones within 1 ms.
`include "ovh_defs.svh"

module sdh_64k_overhead_channel_adapt #(
    parameter int BIT_CYCLES = `OVH_BIT_CYCLES,
    parameter int DEPTH      = `OVH_STORE_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        octet_sel_f1,
    input  wire logic        user_en,
    input  ovh_pkg::ovh_slot_t line_timing_input,
    input  ovh_pkg::ovh_rx_t section_adapted_info,
    input  wire logic        trail_signal_fail,
    output ovh_pkg::ovh_tx_t section_tx,
    input  wire logic        oct_in_clk,
    input  wire logic        oct_in_data,
    input  wire logic        oct_in_frame,
    output ovh_pkg::serial_t octet_channel_side,
    output logic             server_fail_action,
    output logic             alarm_fill_action,
    input  wire logic        user_in_data,
    output ovh_pkg::serial_t user_channel_side,
    output logic             user_server_fail
);
    localparam int LW = $clog2(DEPTH + 2);
    // Octets of wander to ride out on each side of the midpoint
    localparam int WANDER_OCTETS =
        (`OVH_WANDER_NS + `OVH_FRAME_NS - 1) / `OVH_FRAME_NS;
    localparam int FILL_CYCLES = 16 * BIT_CYCLES;
    localparam int FW = $clog2(FILL_CYCLES + 1);

    // Pin synchronisers: clk, data, frame
    logic [2:0] oct_meta;
    logic [2:0] oct_sync;
    logic       oct_clk_d;
    logic       oct_edge;
    logic       user_meta;
    logic       user_sync;

    // Octet assembly from the channel
    logic [7:0] asm_shift;
    logic [7:0] asm_bits;
    logic [2:0] asm_cnt;
    logic       wr_valid;
    logic       wr_ready;
    logic [7:0] wr_data;

    // Elastic store read side
    logic          rd_valid;
    logic          rd_ready;
    logic [7:0]    rd_data;
    logic [LW-1:0] level;
    ovh_pkg::src_state_t state;
    ovh_pkg::src_state_t next_state;
    logic [7:0]    last_octet;
    logic          src_slot;
    logic          take;
    logic          discard;

    // User channel
    logic [7:0] user_shift;
    logic [7:0] user_octet;
    logic       user_bit_end;
    logic       user_octet_end;

    // Sinks
    logic [7:0] oct_hold;
    logic [7:0] user_hold;
    logic       sink_slot;
    logic [FW-1:0] fail_cnt;

    // Both wander margins must fit in the store
    initial begin
        if (`OVH_MID_MARK - `OVH_LOW_MARK < WANDER_OCTETS ||
            `OVH_HIGH_MARK - `OVH_MID_MARK < WANDER_OCTETS ||
            `OVH_HIGH_MARK > DEPTH) begin
            $error("elastic store too shallow for wander");
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            oct_meta  <= 3'h0;
            oct_sync  <= 3'h0;
            oct_clk_d <= 1'b0;
            user_meta <= 1'b1;
            user_sync <= 1'b1;
        end else if (ce) begin
            oct_meta  <= {oct_in_clk, oct_in_data, oct_in_frame};
            oct_sync  <= oct_meta;
            oct_clk_d <= oct_sync[2];
            user_meta <= user_in_data;
            user_sync <= user_meta;
        end
    end

    assign oct_edge = oct_sync[2] && !oct_clk_d;
    assign asm_bits = {asm_shift[6:0], oct_sync[1]};

    // Channel side writes octets into the store on its own clock edges
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            asm_shift <= 8'h00;
            asm_cnt   <= 3'h0;
            wr_valid  <= 1'b0;
            wr_data   <= 8'h00;
        end else if (ce) begin
            if (wr_valid && wr_ready) begin
                wr_valid <= 1'b0;
            end
            if (oct_edge) begin
                asm_shift <= asm_bits;
                if (oct_sync[0]) begin
                    asm_cnt <= 3'h1;
                end else if (asm_cnt != 3'h0) begin
                    // Count only once aligned: a partial octet is dropped
                    asm_cnt <= asm_cnt + 3'h1;
                end
                // A full store stalls this holding octet; a newer one
                // overwrites it, which is itself a slip
                if (!oct_sync[0] && asm_cnt == 3'h7) begin
                    wr_valid <= 1'b1;
                    wr_data  <= asm_bits;
                end
            end
        end
    end

    octet_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .LW    (LW)
    ) store (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .ce       (ce),
        .wr_valid (wr_valid),
        .wr_ready (wr_ready),
        .wr_data  (wr_data),
        .rd_valid (rd_valid),
        .rd_ready (rd_ready),
        .rd_data  (rd_data),
        .level    (level)
    );

    assign src_slot = octet_sel_f1 ? line_timing_input.f1
                                   : line_timing_input.e1;
    assign take     = ce && src_slot && rd_valid &&
                      state == ovh_pkg::SRC_RUN &&
                      level > LW'(`OVH_LOW_MARK);
    // Discard away from the slot so the slot always sees a settled head
    assign discard  = ce && !src_slot && rd_valid &&
                      state == ovh_pkg::SRC_RUN &&
                      level >= LW'(`OVH_HIGH_MARK);
    assign rd_ready = take || discard;

    always_comb begin
        next_state = state;
        case (state)
            ovh_pkg::SRC_PRIME: begin
                if (level >= LW'(`OVH_MID_MARK)) begin
                    next_state = ovh_pkg::SRC_RUN;
                end
            end
            ovh_pkg::SRC_RUN: begin
                next_state = ovh_pkg::SRC_RUN;
            end
            default: begin
                next_state = ovh_pkg::SRC_PRIME;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ovh_pkg::SRC_PRIME;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Byte towards the section: octet channel in its slot, user in F1
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            section_tx <= '{valid: 1'b0, data: `OVH_ALL_ONES};
            last_octet <= `OVH_ALL_ONES;
        end else if (ce) begin
            section_tx.valid <= 1'b0;
            if (src_slot) begin
                section_tx.valid <= 1'b1;
                if (take) begin
                    section_tx.data <= rd_data;
                    last_octet      <= rd_data;
                end else begin
                    section_tx.data <= last_octet;
                end
            end else if (user_en && line_timing_input.f1) begin
                section_tx.valid <= 1'b1;
                section_tx.data  <= user_octet;
            end
        end
    end

    // User source: clock shared with the user sink, bits taken at bit end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            user_shift <= `OVH_ALL_ONES;
            user_octet <= `OVH_ALL_ONES;
        end else if (ce && user_bit_end) begin
            user_shift <= {user_shift[6:0], user_sync};
            if (user_octet_end) begin
                user_octet <= {user_shift[6:0], user_sync};
            end
        end
    end

    assign sink_slot = octet_sel_f1 ? section_adapted_info.f1
                                    : section_adapted_info.e1;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            oct_hold  <= `OVH_ALL_ONES;
            user_hold <= `OVH_ALL_ONES;
        end else if (ce) begin
            if (sink_slot) begin
                oct_hold <= section_adapted_info.data;
            end
            if (section_adapted_info.f1) begin
                user_hold <= section_adapted_info.data;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            server_fail_action <= 1'b0;
            alarm_fill_action  <= 1'b0;
            user_server_fail   <= 1'b0;
        end else if (ce) begin
            server_fail_action <= trail_signal_fail;
            alarm_fill_action  <= trail_signal_fail;
            user_server_fail   <= trail_signal_fail;
        end
    end

    octet_serializer #(
        .BIT_CYCLES (BIT_CYCLES)
    ) octet_out (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .ce         (ce),
        .hold_data  (oct_hold),
        .force_ones (alarm_fill_action),
        .ch         (octet_channel_side),
        .bit_end    (),
        .octet_end  ()
    );

    octet_serializer #(
        .BIT_CYCLES (BIT_CYCLES)
    ) user_out (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .ce         (ce),
        .hold_data  (user_hold),
        .force_ones (user_server_fail),
        .ch         (user_channel_side),
        .bit_end    (user_bit_end),
        .octet_end  (user_octet_end)
    );

    // Helper for the fill checks: cycles of uninterrupted trail fail
    always_ff @(posedge sys_clk) begin
        if (reset || !trail_signal_fail) begin
            fail_cnt <= '0;
        end else if (ce && fail_cnt != FW'(FILL_CYCLES)) begin
            fail_cnt <= fail_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence seq_slot_taken;
        ce && take;
    endsequence

    sequence seq_byte_offered(logic [7:0] b);
        section_tx.valid && section_tx.data == b;
    endsequence

    chk_slot_take_out : assert property (
        seq_slot_taken |=> seq_byte_offered($past(rd_data)))
        else $error("taken octet not offered in its slot");

    chk_repeat_octet : assert property (
        ce && src_slot && !take |=> seq_byte_offered($past(last_octet)))
        else $error("starved slot did not repeat last octet");

    chk_skip_drops : assert property (
        discard && !(wr_valid && wr_ready) |=> level == $past(level) - 1'b1)
        else $error("positive slip did not drop one octet");

    chk_prime_hold : assert property (
        ce && src_slot && state == ovh_pkg::SRC_PRIME
        |=> seq_byte_offered(`OVH_ALL_ONES))
        else $error("store read before reaching midpoint");

    chk_store_latch : assert property (
        ce && sink_slot |=> oct_hold == $past(section_adapted_info.data))
        else $error("received octet not latched");

    chk_fail_flag : assert property (
        ce && trail_signal_fail |=> server_fail_action && user_server_fail)
        else $error("server fail not raised on trail fail");

    chk_octet_fill : assert property (
        fail_cnt == FW'(FILL_CYCLES) |-> octet_channel_side.data)
        else $error("octet channel not all ones under trail fail");

    chk_user_fill : assert property (
        fail_cnt == FW'(FILL_CYCLES) |-> user_channel_side.data)
        else $error("user channel not all ones under trail fail");

    chk_user_in_f1 : assert property (
        ce && user_en && !src_slot && line_timing_input.f1
        |=> seq_byte_offered($past(user_octet)))
        else $error("user octet not placed in F1");

endmodule : sdh_64k_overhead_channel_adapt

//--- verif/channel_equipment.sv
module channel_equipment #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        run,
    input  wire logic [7:0]  user_byte,
    input  ovh_pkg::serial_t user_side,
    output logic             oct_clk,
    output logic             oct_data,
    output logic             oct_frame,
    output logic             user_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int         phase = 0;
    logic [2:0] bitn  = 3'h0;
    logic [2:0] ubit  = 3'h0;
    logic [7:0] octet = 8'h00;
    logic       uclk  = 1'b0;

    initial begin
        oct_clk = 1'b0;
        oct_data = 1'b0;
        oct_frame = 1'b0;
        user_data = 1'b0;
    end

    // Idle: clock stands still, data wanders so a stale bit is never reused
    always @(posedge sys_clk) begin
        if (!run) begin
            oct_clk <= 1'b0;
            oct_frame <= 1'b0;
            oct_data <= ~oct_data;
            phase <= 0;
        end else begin
            phase <= (phase == BIT_CYCLES - 1) ? 0 : phase + 1;
            if (phase == 0) begin
                oct_clk <= 1'b0;
                oct_data <= octet[3'h7 - bitn];
                oct_frame <= (bitn == 3'h0);
                bitn <= bitn + 3'h1;
                if (bitn == 3'h7) begin
                    octet <= octet + 8'h01;
                end
            end else if (phase == BIT_CYCLES / 2) begin
                oct_clk <= 1'b1;
            end
        end
    end

    // New bit at each falling edge of the supplied user clock
    always @(posedge sys_clk) begin
        uclk <= user_side.clk;
        if (uclk && !user_side.clk) begin
            ubit <= user_side.frame ? 3'h0 : ubit + 3'h1;
            user_data <= user_byte[user_side.frame ? 3'h7 : 3'h6 - ubit];
        end
    end
endmodule : channel_equipment

//--- verif/sdh_64k_overhead_channel_adapt_tb.sv
module sdh_64k_overhead_channel_adapt_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 16;
    localparam int OCT = 8 * BC;
    typedef struct packed {
        logic       sel;
        logic       e1;
        logic       f1;
        logic [7:0] data;
        logic       chk_o;
        logic [7:0] exp_o;
        logic       chk_u;
        logic [7:0] exp_u;
    } row_t;
    row_t rows [4] = '{
        '{1'b0, 1'b0, 1'b1, 8'h3C, 1'b0, 8'h00, 1'b1, 8'h3C},
        '{1'b0, 1'b1, 1'b0, 8'hA5, 1'b1, 8'hA5, 1'b1, 8'h3C},
        '{1'b1, 1'b0, 1'b1, 8'hC3, 1'b1, 8'hC3, 1'b1, 8'hC3},
        '{1'b1, 1'b1, 1'b0, 8'h5A, 1'b1, 8'hC3, 1'b1, 8'hC3}
    };
    logic               sys_clk = 1'b0;
    logic               reset   = 1'b1;
    logic               ce      = 1'b1;
    logic               sel     = 1'b0;
    logic               uen     = 1'b0;
    logic               tsf     = 1'b0;
    logic               run     = 1'b0;
    ovh_pkg::ovh_slot_t slot    = '0;
    ovh_pkg::ovh_rx_t   rx      = '0;
    ovh_pkg::ovh_tx_t   tx;
    ovh_pkg::serial_t   och;
    ovh_pkg::serial_t   uch;
    logic               ssf, ais, ussf, oclk, odat, ofrm, udat;
    logic [7:0]         got;
    int                 fails = 0;
    int                 comparisons = 0;
    int                 cycles = 0;
    int                 reps, skips;

    always #12.5 sys_clk = ~sys_clk;

    sdh_64k_overhead_channel_adapt #(.BIT_CYCLES(BC), .DEPTH(8)) DUT (
        .sys_clk(sys_clk), .reset(reset), .ce(ce), .octet_sel_f1(sel),
        .user_en(uen), .line_timing_input(slot), .section_adapted_info(rx),
        .trail_signal_fail(tsf), .section_tx(tx), .oct_in_clk(oclk),
        .oct_in_data(odat), .oct_in_frame(ofrm), .octet_channel_side(och),
        .server_fail_action(ssf), .alarm_fill_action(ais),
        .user_in_data(udat), .user_channel_side(uch),
        .user_server_fail(ussf));

    channel_equipment #(.BIT_CYCLES(BC)) eq (
        .sys_clk(sys_clk), .run(run), .user_byte(8'hA6), .user_side(uch),
        .oct_clk(oclk), .oct_data(odat), .oct_frame(ofrm),
        .user_data(udat));

    task automatic complete_run();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    // Slot pulse for one cycle; answer must stand exactly the next cycle
    task automatic send_slot(input logic f1, output logic [7:0] d);
        slot.e1 = ~f1;
        slot.f1 = f1;
        tick(1);
        slot = '0;
        check({7'h00, tx.valid}, 8'h01);
        d = tx.data;
        tick(1);
        check({7'h00, tx.valid}, 8'h00);
    endtask : send_slot

    task automatic step(input logic u, inout ovh_pkg::serial_t s, inout int n);
        tick(1);
        s = u ? uch : och;
        n++;
    endtask : step

    // Frame marks the first bit; bits are taken while the clock is high
    task automatic capture(input logic u, output logic [7:0] d);
        ovh_pkg::serial_t s;
        int n;
        n = 0;
        s = u ? uch : och;
        while (!(s.frame && s.clk) && n < 3000) step(u, s, n);
        for (int i = 7; i >= 0; i--) begin
            while (!s.clk && n < 3000) step(u, s, n);
            d[i] = s.data;
            while (s.clk && n < 3000) step(u, s, n);
        end
        check({7'h00, n < 3000}, 8'h01);
    endtask : capture

    task automatic src_run(input logic f1, input int gap, input int n,
                           output int r, output int k);
        logic [7:0] d, prev;
        logic have;
        r = 0;
        k = 0;
        have = 1'b0;
        sel = f1;
        for (int i = 0; i < n; i++) begin
            send_slot(f1, d);
            tick(gap - 2);
            // Priming fill is skipped; the first slots let marks settle
            if (d !== 8'hFF) begin
                if (have && i > 4) begin
                    if (d == prev) r++;
                    else if (d == prev + 8'h02 || d == prev + 8'h03) k++;
                    else check(d, prev + 8'h01);
                end
                prev = d;
                have = 1'b1;
            end
        end
    endtask : src_run

    task automatic check_reset();
        check({2'b00, och, uch}, 8'h12);
        check({4'h0, tx.valid, ssf, ais, ussf}, 8'h00);
        check(tx.data, 8'hFF);
    endtask : check_reset

    initial begin
        tick(20);
        reset = 1'b0;
        check_reset();
        foreach (rows[i]) begin
            sel = rows[i].sel;
            rx = {rows[i].e1, rows[i].f1, rows[i].data};
            tick(1);
            rx = {2'b00, ~rows[i].data};
            tick(2 * OCT);
            if (rows[i].chk_o) begin
                capture(1'b0, got);
                check(got, rows[i].exp_o);
            end
            if (rows[i].chk_u) begin
                capture(1'b1, got);
                check(got, rows[i].exp_u);
            end
        end
        tsf = 1'b1;
        tick(1);
        check({5'h00, ssf, ais, ussf}, 8'h07);
        tick(2 * OCT);
        capture(1'b0, got);
        check(got, 8'hFF);
        capture(1'b1, got);
        check(got, 8'hFF);
        tsf = 1'b0;
        tick(1);
        check({5'h00, ssf, ais, ussf}, 8'h00);
        tick(2 * OCT);
        capture(1'b0, got);
        check(got, 8'hC3);
        capture(1'b1, got);
        check(got, 8'hC3);
        run = 1'b1;
        sel = 1'b0;
        slot.f1 = 1'b1;
        tick(1);
        slot = '0;
        check({7'h00, tx.valid}, 8'h00);
        tick(1);
        uen = 1'b1;
        repeat (12) begin
            send_slot(1'b1, got);
            tick(OCT - 2);
        end
        check(got, 8'hA6);
        uen = 1'b0;
        src_run(1'b0, 90, 40, reps, skips);
        check({6'h00, reps > 0, skips > 0}, 8'h02);
        src_run(1'b1, 160, 50, reps, skips);
        check({6'h00, reps > 0, skips > 0}, 8'h01);
        // Clock enable low: half a bit off the period so a live clock shows
        ce = 1'b0;
        got = {5'h00, och};
        slot.f1 = 1'b1;
        tick(OCT + BC / 2);
        slot = '0;
        check({5'h00, och}, got);
        check({7'h00, tx.valid}, 8'h00);
        ce = 1'b1;
        reset = 1'b1;
        tick(2);
        check_reset();
        reset = 1'b0;
        tick(2);
        check_reset();
        send_slot(sel, got);
        check(got, 8'hFF);
        complete_run();
    end
endmodule : sdh_64k_overhead_channel_adapt_tb
